// ### bench/gdfs_ctrl_model.sv
// partner model: controller board driving pwm and reading the fault lines
`timescale 1ns/10ps
module gdfs_ctrl_model
    import gdfs_pkg::*;
(
    input  wire logic [NUM_CHAN-1:0] i_pwm_cmd,
    input  wire gdfs_od_pin_s        i_fault_a,
    input  wire gdfs_od_pin_s        i_fault_b,
    output logic [NUM_CHAN-1:0]      o_pwm,
    output logic                     o_fault_line_a,
    output logic                     o_fault_line_b,
    output logic                     o_fault_wired
);
    // board pull-ups: a released line reads high, never the last value
    assign o_fault_line_a = i_fault_a.oe ? i_fault_a.out : 1'b1;
    assign o_fault_line_b = i_fault_b.oe ? i_fault_b.out : 1'b1;
    assign o_fault_wired  = o_fault_line_a & o_fault_line_b;
    // levels pass straight on; the bench changes them off the sampling edge
    assign o_pwm = i_pwm_cmd;
endmodule

// ### bench/gdfs_props.sv
// checker: concurrent properties on the fault supervisor ports
`timescale 1ns/10ps
module gdfs_props
    import gdfs_pkg::*;
#(
    parameter int unsigned RESTART_CAP_PF = RESTART_CAP_PF_DEF
) (
    input wire logic                i_ref_clk,
    input wire logic                i_rst_n,
    input wire logic                i_supply_above_lockout,
    input wire logic                i_vdd_power_good,
    input wire logic [NUM_CHAN-1:0] i_pwm_input_chan,
    input wire logic [NUM_CHAN-1:0] i_sec_fault,
    input wire gdfs_od_pin_s        o_fault_out_chan_a,
    input wire gdfs_od_pin_s        o_fault_out_chan_b,
    input wire gdfs_tx_pair_s       o_mod_tx_pair_a,
    input wire gdfs_tx_pair_s       o_mod_tx_pair_b,
    input wire logic                o_converter_switch_drive,
    input wire logic                o_converter_clock,
    input wire logic                o_primary_fault
);
    // primary fault stands the whole restart period, after reset as in run
    localparam int HOLD_MIN = RESTART_CAP_PF * RESTART_NS_PER_PF / REF_CLK_PERIOD_NS;
    logic [RESTART_CNT_W-1:0] fault_len_reg;
    logic [CONV_PHASE_W-1:0]  clk_high_reg;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || !o_primary_fault)
            fault_len_reg <= '0;
        else
            fault_len_reg <= fault_len_reg + 1'b1;
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || !o_converter_clock)
            clk_high_reg <= '0;
        else
            clk_high_reg <= clk_high_reg + 1'b1;
    end
    sequence s_pulse_gap;
        !o_converter_switch_drive ##1 !o_converter_switch_drive;
    endsequence
    AST_CAUSE: assert property ((!o_primary_fault && (!i_supply_above_lockout
        || !i_vdd_power_good)) |-> ##[1:4] o_primary_fault) else $error("cause not seen");
    AST_HOLD: assert property ($fell(o_primary_fault) |-> fault_len_reg >= HOLD_MIN)
        else $error("fault released early");
    AST_OUT_A: assert property (o_fault_out_chan_a.oe == (o_primary_fault
        || $past(i_sec_fault[CHAN_A]))) else $error("fault a mismatch");
    AST_OUT_B: assert property (o_fault_out_chan_b.oe == (o_primary_fault
        || $past(i_sec_fault[CHAN_B]))) else $error("fault b mismatch");
    AST_OD_LOW: assert property (!o_fault_out_chan_a.out && !o_fault_out_chan_b.out)
        else $error("open drain drives high");
    AST_TX_OFF: assert property (o_primary_fault |-> o_mod_tx_pair_a == TX_PAIR_IDLE
        && o_mod_tx_pair_b == TX_PAIR_IDLE) else $error("tx active in fault");
    AST_DRV_OFF: assert property (o_primary_fault |-> !o_converter_switch_drive)
        else $error("converter on in fault");
    AST_CAP: assert property (o_converter_switch_drive |-> o_converter_clock)
        else $error("drive beyond clock high");
    AST_DELAY: assert property ($rose(o_converter_clock) |-> s_pulse_gap)
        else $error("pulse delay short");
    AST_HIGH: assert property ($fell(o_converter_clock)
        |-> clk_high_reg == CONV_CLK_HIGH_CYC) else $error("clock high time");
    AST_TX_COMP: assert property ((o_mod_tx_pair_a.pos || o_mod_tx_pair_a.neg)
        |-> o_mod_tx_pair_a.pos != o_mod_tx_pair_a.neg) else $error("tx a not complementary");
endmodule
bind gdfs_supervisor gdfs_props #(.RESTART_CAP_PF(RESTART_CAP_PF)) u_gdfs_props (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_supply_above_lockout(i_supply_above_lockout),
    .i_vdd_power_good(i_vdd_power_good), .i_pwm_input_chan(i_pwm_input_chan),
    .i_sec_fault(i_sec_fault), .o_fault_out_chan_a(o_fault_out_chan_a),
    .o_fault_out_chan_b(o_fault_out_chan_b), .o_mod_tx_pair_a(o_mod_tx_pair_a),
    .o_mod_tx_pair_b(o_mod_tx_pair_b), .o_converter_switch_drive(o_converter_switch_drive),
    .o_converter_clock(o_converter_clock), .o_primary_fault(o_primary_fault));

// ### bench/test_gdfs_supervisor.sv
// self-checking testbench of the fault supervisor
`timescale 1ns/10ps
module test_gdfs_supervisor;
    import gdfs_pkg::*;
    localparam int unsigned CAP_PF = 2;
    localparam int HOLD_CYC = CAP_PF * RESTART_NS_PER_PF / REF_CLK_PERIOD_NS;
    localparam int FULL_W   = CONV_CLK_HIGH_CYC - CONV_PULSE_DELAY_CYC;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_supply_above_lockout = 1'b1, i_vdd_power_good = 1'b1;
    logic [1:0] i_sec_fault = '0, pwm_cmd = '0, pwm;
    logic line_a, line_b, wired, drive, conv_clk, prim;
    gdfs_od_pin_s  flt_a, flt_b;
    gdfs_tx_pair_s tx_a, tx_b;
    int n_mismatch = 0, cmp_count = 0, n;
    gdfs_supervisor #(.RESTART_CAP_PF(CAP_PF), .SOFT_START_CYC(800)) u_gdfs_supervisor (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_supply_above_lockout(i_supply_above_lockout),
        .i_vdd_power_good(i_vdd_power_good), .i_pwm_input_chan(pwm), .i_sec_fault(i_sec_fault),
        .o_fault_out_chan_a(flt_a), .o_fault_out_chan_b(flt_b), .o_mod_tx_pair_a(tx_a),
        .o_mod_tx_pair_b(tx_b), .o_converter_switch_drive(drive), .o_converter_clock(conv_clk),
        .o_primary_fault(prim));
    gdfs_ctrl_model u_gdfs_ctrl_model (.i_pwm_cmd(pwm_cmd),
        .i_fault_a(flt_a), .i_fault_b(flt_b), .o_pwm(pwm), .o_fault_line_a(line_a),
        .o_fault_line_b(line_b), .o_fault_wired(wired));
    always #12.5 i_ref_clk = ~i_ref_clk;
    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(negedge i_ref_clk);
    endtask
    // counts negedges until the primary fault shows lvl, bounded by lim
    task automatic wait_fault(logic lvl, int lim, output int cnt);
        cnt = 0;
        do begin
            cyc(1);
            cnt++;
        end while (prim !== lvl && cnt < lim);
    endtask
    task automatic pulse_w(output int w);
        w = 0;
        for (int k = 0; k < 300 && drive === 1'b1; k++) cyc(1);
        for (int k = 0; k < 500 && drive !== 1'b1; k++) cyc(1);
        while (drive === 1'b1 && w < 300) begin
            cyc(1);
            w++;
        end
    endtask
    task automatic t_startup();
        chk("fault pins", 8'h03, {flt_a.oe, flt_b.oe});
        chk("idle outputs", 8'h01, {tx_a, tx_b, drive, prim});
        cyc(2);
        i_rst_n = 1'b1;
        cyc(HOLD_CYC - 4);
        chk("held after reset", 8'h01, prim);
        wait_fault(1'b0, 10, n);
        chk("run entered", 8'h00, prim);
        chk("wired released", 8'h01, wired);
    endtask
    task automatic t_softstart();
        int w0, w1;
        pulse_w(w0);
        cyc(1200);
        pulse_w(w1);
        chk("early pulse seen", 8'h01, w0 > 0);
        chk("early pulse short", 8'h01, w0 < FULL_W);
        chk("full pulse", FULL_W[7:0], w1[7:0]);
    endtask
    task automatic t_sec();
        for (int s = 0; s < 4; s++) begin
            i_sec_fault = s[1:0];
            cyc(2);
            chk("oe pair", {6'h00, s[0], s[1]}, {flt_a.oe, flt_b.oe});
            chk("wired line", {7'h00, s == 0}, wired);
        end
        i_sec_fault = '0;
    endtask
    task automatic t_restart();
        for (int c = 0; c < 2; c++) begin
            if (c == 0) i_supply_above_lockout = 1'b0;
            else i_vdd_power_good = 1'b0;
            cyc(1);
            i_supply_above_lockout = 1'b1;
            i_vdd_power_good = 1'b1;
            wait_fault(1'b1, 6, n);
            chk("fault raised", 8'h01, prim);
            chk("lines low", 8'h00, {line_a, line_b});
            wait_fault(1'b0, 200, n);
            chk("hold length", HOLD_CYC[7:0], n[7:0]);
        end
    endtask
    task automatic t_stuck();
        i_vdd_power_good = 1'b0;
        cyc(3 * HOLD_CYC);
        chk("stuck fault", 8'h01, prim);
        i_vdd_power_good = 1'b1;
        wait_fault(1'b0, 6, n);
        chk("fault left", 8'h00, prim);
    endtask
    task automatic t_pwm();
        pwm_cmd = 2'b11;
        cyc(4);
        chk("tx a follows", 8'h01, tx_a != TX_PAIR_IDLE);
        i_supply_above_lockout = 1'b0;
        cyc(6);
        i_supply_above_lockout = 1'b1;
        chk("tx forced off", 8'h00, {tx_a, tx_b});
        wait_fault(1'b0, HOLD_CYC + 10, n);
        cyc(10);
        chk("tx waits edge", 8'h00, {tx_a, tx_b});
        pwm_cmd = 2'b00;
        cyc(3);
        pwm_cmd = 2'b11;
        cyc(4);
        chk("tx rearmed", 8'h01, tx_a.pos != tx_a.neg && tx_b.pos != tx_b.neg);
        pwm_cmd = 2'b00;
    endtask
    initial begin
        #(REF_CLK_PERIOD_NS * 20000);
        n_mismatch++;
        results();
    end
    initial begin
        cyc(1);
        t_startup();
        t_softstart();
        t_sec();
        t_restart();
        t_stuck();
        t_pwm();
        results();
    end
endmodule

// ### design/gdfs_pkg.sv
// gdfs_pkg: shared constants and types of the gate-driver fault supervisor
package gdfs_pkg;

    // reference clock
    localparam int unsigned REF_CLK_PERIOD_NS = 25;

    // restart delay: 0.5 us per picofarad of timing capacitor
    localparam int unsigned RESTART_NS_PER_PF = 500;
    localparam int unsigned RESTART_CAP_PF_DEF = 100;
    localparam int unsigned RESTART_CNT_W = 24;

    // converter clock: 180 kHz, 90 percent high
    localparam int unsigned CONV_CLK_FREQ_KHZ = 180;
    localparam int unsigned CONV_CLK_HIGH_PCT = 90;
    localparam int unsigned CONV_CLK_PERIOD_CYC =
        (1000000 / REF_CLK_PERIOD_NS) / CONV_CLK_FREQ_KHZ;
    localparam int unsigned CONV_CLK_HIGH_CYC =
        (CONV_CLK_PERIOD_CYC * CONV_CLK_HIGH_PCT) / 100;
    localparam int unsigned CONV_PHASE_W = 8;
    // delay from converter clock rise to switch pulse start
    localparam int unsigned CONV_PULSE_DELAY_CYC = 2;

    // soft-start time constant, 2 ms
    localparam int unsigned SOFT_START_US = 2000;
    localparam int unsigned SOFT_START_CYC_DEF =
        (SOFT_START_US * 1000) / REF_CLK_PERIOD_NS;
    localparam int unsigned SOFT_START_CNT_W = 20;

    // on-off keying carrier half period for the transmit pairs
    localparam int unsigned TX_CARRIER_HALF_CYC_DEF = 2;
    localparam int unsigned TX_CARRIER_CNT_W = 8;

    localparam int unsigned NUM_CHAN = 2;
    localparam int unsigned CHAN_A = 0;
    localparam int unsigned CHAN_B = 1;

    // supervisor states, gray along hold -> wait -> run
    typedef enum logic [1:0] {
        GDFS_FAULT_HOLD = 2'b00,
        GDFS_FAULT_WAIT = 2'b01,
        GDFS_RUN        = 2'b11
    } gdfs_state_e;

    // open-drain pin: oe high while the pin is pulled low
    typedef struct packed {
        logic out;
        logic oe;
    } gdfs_od_pin_s;

    // differential modulated transmit pair
    typedef struct packed {
        logic pos;
        logic neg;
    } gdfs_tx_pair_s;

    localparam gdfs_tx_pair_s TX_PAIR_IDLE = '{pos: 1'b0, neg: 1'b0};
    localparam gdfs_od_pin_s  OD_PULL_LOW  = '{out: 1'b0, oe: 1'b1};
    localparam gdfs_od_pin_s  OD_RELEASE   = '{out: 1'b0, oe: 1'b0};

endpackage

// ### design/gdfs_supervisor.sv
// gdfs_supervisor: primary fault supervision, restart timing and soft-start
//
// How it works
// - fault raised when supply under lockout or regulator below power-good
// - both causes ORed into one primary fault
// - primary fault held for restart period even if cause clears sooner
// - restart period is 0.5 us per picofarad, set by a parameter
// - while fault is held both fault outputs pull low
// - while fault is held transmit pairs are zero and converter is off
// - at period end with cause active, stay in fault until it clears
// - at period end with no cause, leave fault, enable converter and data
// - after fault exit each channel waits for next rising pwm input edge
// - fault A is primary or secondary A; fault B primary or secondary B
// - at power-up everything is held in fault state, outputs low
// - normal operation only with power-good and supply above upper level
// - 2 ms soft-start on every power-up and every fault exit
// - converter clock rise starts switch pulse after delay; high time caps duty
// - converter clock defaults to 180 kHz with 90 percent high
// - fault outputs are open drain, only pulling low
// - low fault output means fault, so wired outputs form a fault-OR
// - internal pwm forced to zero from the second cycle of a primary fault to its end
`timescale 1ns/10ps
module gdfs_supervisor
    import gdfs_pkg::*;
#(
    parameter int unsigned RESTART_CAP_PF    = RESTART_CAP_PF_DEF,
    parameter int unsigned SOFT_START_CYC    = SOFT_START_CYC_DEF,
    parameter int unsigned TX_CARRIER_HALF   = TX_CARRIER_HALF_CYC_DEF
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_supply_above_lockout,
    input  wire logic                  i_vdd_power_good,
    input  wire logic [NUM_CHAN-1:0]   i_pwm_input_chan,
    input  wire logic [NUM_CHAN-1:0]   i_sec_fault,
    output gdfs_od_pin_s               o_fault_out_chan_a,
    output gdfs_od_pin_s               o_fault_out_chan_b,
    output gdfs_tx_pair_s              o_mod_tx_pair_a,
    output gdfs_tx_pair_s              o_mod_tx_pair_b,
    output logic                       o_converter_switch_drive,
    output logic                       o_converter_clock,
    output logic                       o_primary_fault
);

    localparam longint unsigned RESTART_CYC_L =
        (longint'(RESTART_CAP_PF) * RESTART_NS_PER_PF) / REF_CLK_PERIOD_NS;
    localparam logic [RESTART_CNT_W-1:0] RESTART_LOAD =
        RESTART_CNT_W'(RESTART_CYC_L - 1);
    localparam int unsigned SS_STEP_CYC = SOFT_START_CYC / CONV_CLK_HIGH_CYC;
    localparam logic [SOFT_START_CNT_W-1:0] SS_STEP_LAST =
        SOFT_START_CNT_W'(SS_STEP_CYC - 1);
    localparam logic [CONV_PHASE_W-1:0] PHASE_LAST =
        CONV_PHASE_W'(CONV_CLK_PERIOD_CYC - 1);
    localparam logic [CONV_PHASE_W-1:0] PHASE_HIGH =
        CONV_PHASE_W'(CONV_CLK_HIGH_CYC);
    localparam logic [CONV_PHASE_W-1:0] PHASE_DELAY =
        CONV_PHASE_W'(CONV_PULSE_DELAY_CYC);
    localparam logic [TX_CARRIER_CNT_W-1:0] CARRIER_LAST =
        TX_CARRIER_CNT_W'(TX_CARRIER_HALF - 1);

    // refuse values the counters cannot hold
    generate
        if (RESTART_CYC_L < 1 || RESTART_CYC_L > (64'd1 << RESTART_CNT_W)) begin : g_bad_restart
            $error("restart capacitor value out of counter range");
        end
        if (SS_STEP_CYC < 1 || SS_STEP_CYC > (1 << SOFT_START_CNT_W)) begin : g_bad_ss
            $error("soft-start length out of counter range");
        end
        if (TX_CARRIER_HALF < 1 || TX_CARRIER_HALF > (1 << TX_CARRIER_CNT_W)) begin : g_bad_tx
            $error("carrier half period out of counter range");
        end
        if (CONV_CLK_PERIOD_CYC > (1 << CONV_PHASE_W)) begin : g_bad_conv
            $error("converter clock period out of phase counter range");
        end
        if (CONV_CLK_HIGH_CYC >= CONV_CLK_PERIOD_CYC) begin : g_bad_high
            $error("converter clock high time leaves no low phase");
        end
        if (CONV_CLK_HIGH_CYC <= CONV_PULSE_DELAY_CYC) begin : g_bad_pulse
            $error("pulse delay leaves no on-time inside the clock high time");
        end
    endgenerate

    // input synchronisers
    logic [1:0] uv_sync_reg;
    logic [1:0] pg_sync_reg;

    // both reset to the fault side, so start-up never sees a false good supply
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            uv_sync_reg <= 2'h3;
        end else begin
            uv_sync_reg <= {uv_sync_reg[0], ~i_supply_above_lockout};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pg_sync_reg <= 2'h0;
        end else begin
            pg_sync_reg <= {pg_sync_reg[0], i_vdd_power_good};
        end
    end

    logic fault_cause;
    assign fault_cause = uv_sync_reg[1] | ~pg_sync_reg[1];

    // supervisor state and restart timer
    gdfs_state_e               state_reg;
    gdfs_state_e               state_next;
    logic [RESTART_CNT_W-1:0]  restart_cnt_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            GDFS_FAULT_HOLD: begin
                if (restart_cnt_reg == '0) begin
                    state_next = fault_cause ? GDFS_FAULT_WAIT : GDFS_RUN;
                end
            end
            GDFS_FAULT_WAIT: begin
                if (!fault_cause) begin
                    state_next = GDFS_RUN;
                end
            end
            GDFS_RUN: begin
                if (fault_cause) begin
                    state_next = GDFS_FAULT_HOLD;
                end
            end
        endcase
    end

    // reset lands in hold so start-up behaves like a fault
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_reg <= GDFS_FAULT_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // a cause seen while held does not reload; the period runs from first entry
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            restart_cnt_reg <= RESTART_LOAD;
        end else if (state_reg == GDFS_RUN && fault_cause) begin
            restart_cnt_reg <= RESTART_LOAD;
        end else if (state_reg == GDFS_FAULT_HOLD && restart_cnt_reg != '0) begin
            restart_cnt_reg <= restart_cnt_reg - 1'b1;
        end
    end

    logic run_next;
    assign run_next = (state_next == GDFS_RUN);

    // pwm arming per channel and on-off keyed transmit
    logic [TX_CARRIER_CNT_W-1:0] carrier_cnt_reg;
    logic                        carrier_reg;

    // carrier runs free so the first mark after arming has a clean phase
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            carrier_cnt_reg <= '0;
            carrier_reg     <= 1'b0;
        end else if (carrier_cnt_reg == CARRIER_LAST) begin
            carrier_cnt_reg <= '0;
            carrier_reg     <= ~carrier_reg;
        end else begin
            carrier_cnt_reg <= carrier_cnt_reg + 1'b1;
        end
    end

    logic [NUM_CHAN-1:0] pwm_prev_reg;
    logic [NUM_CHAN-1:0] pwm_armed_reg;
    logic [NUM_CHAN-1:0] pwm_int;
    gdfs_tx_pair_s       tx_reg [NUM_CHAN];
    gdfs_od_pin_s        fault_reg [NUM_CHAN];

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
            // resets high so a line already high at reset is no edge
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    pwm_prev_reg[ch] <= 1'b1;
                end else begin
                    pwm_prev_reg[ch] <= i_pwm_input_chan[ch];
                end
            end

            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    pwm_armed_reg[ch] <= 1'b0;
                end else if (state_reg != GDFS_RUN) begin
                    pwm_armed_reg[ch] <= 1'b0;
                end else if (i_pwm_input_chan[ch] && !pwm_prev_reg[ch]) begin
                    pwm_armed_reg[ch] <= 1'b1;
                end
            end

            // a level already high at fault exit does not count as an edge
            assign pwm_int[ch] = pwm_armed_reg[ch] & i_pwm_input_chan[ch];

            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    tx_reg[ch] <= TX_PAIR_IDLE;
                end else if (run_next && pwm_int[ch]) begin
                    tx_reg[ch] <= '{pos: carrier_reg, neg: ~carrier_reg};
                end else begin
                    tx_reg[ch] <= TX_PAIR_IDLE;
                end
            end

            // looks at the next state so the pins move with the primary fault flag
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    fault_reg[ch] <= OD_PULL_LOW;
                end else if (!run_next || i_sec_fault[ch]) begin
                    fault_reg[ch] <= OD_PULL_LOW;
                end else begin
                    fault_reg[ch] <= OD_RELEASE;
                end
            end
        end
    endgenerate

    // converter clock: free-running phase counter
    logic [CONV_PHASE_W-1:0] phase_reg;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            // last phase, so the first high time after reset is full length
            phase_reg <= PHASE_LAST;
        end else if (phase_reg == PHASE_LAST) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_reg + 1'b1;
        end
    end

    // soft-start: allowed on-time grows one cycle per step up to the clock high time
    logic [SOFT_START_CNT_W-1:0] ss_cnt_reg;
    logic [CONV_PHASE_W-1:0]     ss_limit_reg;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || state_reg != GDFS_RUN) begin
            ss_cnt_reg   <= '0;
            ss_limit_reg <= PHASE_DELAY;
        end else if (ss_limit_reg != PHASE_HIGH) begin
            if (ss_cnt_reg == SS_STEP_LAST) begin
                ss_cnt_reg   <= '0;
                ss_limit_reg <= ss_limit_reg + 1'b1;
            end else begin
                ss_cnt_reg <= ss_cnt_reg + 1'b1;
            end
        end
    end

    function automatic logic [CONV_PHASE_W-1:0] phase_next_f(
        input logic [CONV_PHASE_W-1:0] p
    );
        phase_next_f = (p == PHASE_LAST) ? '0 : p + 1'b1;
    endfunction

    logic conv_clk_next;
    logic drive_next;
    assign conv_clk_next = (phase_next_f(phase_reg) < PHASE_HIGH);
    // pulse opens after the delay from clock rise, closes by soft-start or clock fall
    assign drive_next = run_next && (state_reg == GDFS_RUN)
                        && (phase_next_f(phase_reg) >= PHASE_DELAY)
                        && (phase_next_f(phase_reg) < ss_limit_reg);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_converter_clock <= 1'b0;
        end else begin
            o_converter_clock <= conv_clk_next;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_converter_switch_drive <= 1'b0;
        end else begin
            o_converter_switch_drive <= drive_next;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_primary_fault <= 1'b1;
        end else begin
            o_primary_fault <= !run_next;
        end
    end

    assign o_fault_out_chan_a = fault_reg[CHAN_A];
    assign o_fault_out_chan_b = fault_reg[CHAN_B];
    assign o_mod_tx_pair_a    = tx_reg[CHAN_A];
    assign o_mod_tx_pair_b    = tx_reg[CHAN_B];

endmodule
